// [hdl/bsc_boundary_scan.sv]
`timescale 1ns/10ps
// ============================================================
// Boundary-scan test logic, sampled on core_clk
// Functional notes
// R1 - Four-wire test port per standard behaviour
// R2 - TDI and TMS sampled on TCK rise
// R3 - TDO changes on TCK fall
// R4 - Cell per digital pin, none on test pins
// R5 - Boundary path is exactly 59 cells
// R6 - Cell 1 nearest TDO, shifted first
// R7 - Variant test pins still act as cells
// R8 - Cells 1-34: bypass, overlay, composite, pixel data
// R9 - Cells 35-48: strobes, clocks, syncs, host control
// R10 - Cells 49-59: control, video syncs, host data
// R11 - Standard controller with BYPASS, SAMPLE, EXTEST
// R12 - Pins transparent unless boundary test selected
module bsc_boundary_scan import bsc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  input  wire logic [58:0] pin_value,
  input  wire logic [58:0] core_drive,
  input  wire logic [58:0] core_drive_oe,
  output logic      [58:0] pin_drive,
  output logic      [58:0] pin_drive_oe
);

  // ==========================================================
  // Declarations
  logic              tck_meta;
  logic              tck_sync;
  logic              tck_last;
  logic              tms_meta;
  logic              tms_sync;
  logic              tdi_meta;
  logic              tdi_sync;
  logic [58:0]       pin_meta;
  logic [58:0]       pin_sync;
  logic              tck_rise;
  logic              tck_fall;

  bsc_tap_state_type state;
  bsc_tap_state_type next_state;

  logic [1:0]        ir_shift;
  logic [1:0]        next_ir_shift;
  logic [1:0]        ir;
  logic [1:0]        next_ir;
  logic              bypass_bit;
  logic              next_bypass_bit;
  logic              next_tdo;
  logic              next_tdo_oe;

  logic              boundary_sel;
  logic              extest_on;
  logic              bs_capture;
  logic              bs_shift;
  logic              bs_update;
  logic [58:0]       chain;
  logic [58:0]       latch;
  logic [58:0]       next_pin_drive;
  logic [58:0]       next_pin_drive_oe;

  logic [2:0]        ones_cnt;
  logic [2:0]        next_ones_cnt;

  // ==========================================================
  // Synchronisers for the test pins and the sampled pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tck_meta <= 1'b0;
      tck_sync <= 1'b0;
      tck_last <= 1'b0;
      tms_meta <= 1'b1;
      tms_sync <= 1'b1;
      tdi_meta <= 1'b1;
      tdi_sync <= 1'b1;
      pin_meta <= BSC_CHAIN_RESET;
      pin_sync <= BSC_CHAIN_RESET;
    end else begin
      tck_meta <= tck;
      tck_sync <= tck_meta;
      tck_last <= tck_sync;
      tms_meta <= tms;
      tms_sync <= tms_meta;
      tdi_meta <= tdi;
      tdi_sync <= tdi_meta;
      pin_meta <= pin_value;
      pin_sync <= pin_meta;
    end
  end

  // Test clock edges
  assign tck_rise = tck_sync & ~tck_last;                 // R2
  assign tck_fall = ~tck_sync & tck_last;                 // R3

  // ==========================================================
  // Controller state, advanced on each test clock rise
  always_comb begin
    next_state = state;
    if (tck_rise) begin                                   // R2
      unique case (state)                                 // R11
        BSC_ST_RESET:  next_state = tms_sync ? BSC_ST_RESET  : BSC_ST_IDLE;
        BSC_ST_IDLE:   next_state = tms_sync ? BSC_ST_SEL_DR : BSC_ST_IDLE;
        BSC_ST_SEL_DR: next_state = tms_sync ? BSC_ST_SEL_IR : BSC_ST_CAP_DR;
        BSC_ST_CAP_DR: next_state = tms_sync ? BSC_ST_EX1_DR : BSC_ST_SH_DR;
        BSC_ST_SH_DR:  next_state = tms_sync ? BSC_ST_EX1_DR : BSC_ST_SH_DR;
        BSC_ST_EX1_DR: next_state = tms_sync ? BSC_ST_UPD_DR : BSC_ST_PA_DR;
        BSC_ST_PA_DR:  next_state = tms_sync ? BSC_ST_EX2_DR : BSC_ST_PA_DR;
        BSC_ST_EX2_DR: next_state = tms_sync ? BSC_ST_UPD_DR : BSC_ST_SH_DR;
        BSC_ST_UPD_DR: next_state = tms_sync ? BSC_ST_SEL_DR : BSC_ST_IDLE;
        BSC_ST_SEL_IR: next_state = tms_sync ? BSC_ST_RESET  : BSC_ST_CAP_IR;
        BSC_ST_CAP_IR: next_state = tms_sync ? BSC_ST_EX1_IR : BSC_ST_SH_IR;
        BSC_ST_SH_IR:  next_state = tms_sync ? BSC_ST_EX1_IR : BSC_ST_SH_IR;
        BSC_ST_EX1_IR: next_state = tms_sync ? BSC_ST_UPD_IR : BSC_ST_PA_IR;
        BSC_ST_PA_IR:  next_state = tms_sync ? BSC_ST_EX2_IR : BSC_ST_PA_IR;
        BSC_ST_EX2_IR: next_state = tms_sync ? BSC_ST_UPD_IR : BSC_ST_SH_IR;
        BSC_ST_UPD_IR: next_state = tms_sync ? BSC_ST_SEL_DR : BSC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BSC_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Instruction, bypass bit and test data output
  always_comb begin
    next_ir_shift   = ir_shift;
    next_ir         = ir;
    next_bypass_bit = bypass_bit;
    next_tdo        = tdo;
    next_tdo_oe     = tdo_oe;
    if (tck_rise) begin
      // Capture and shift on the rise
      if (state == BSC_ST_CAP_IR) begin
        next_ir_shift = BSC_IR_CAPTURE;                   // R11
      end else if (state == BSC_ST_SH_IR) begin
        next_ir_shift = {tdi_sync, ir_shift[1]};          // R2
      end
      if (state == BSC_ST_CAP_DR) begin
        next_bypass_bit = 1'b0;
      end else if (state == BSC_ST_SH_DR) begin
        next_bypass_bit = tdi_sync;                       // R11
      end
    end
    if (tck_fall) begin
      // Update and output on the fall
      if (state == BSC_ST_UPD_IR) begin
        next_ir = ir_shift;
      end
      if (state == BSC_ST_SH_DR) begin
        next_tdo    = boundary_sel ? chain[0] : bypass_bit;  // R6
        next_tdo_oe = 1'b1;                               // R3
      end else if (state == BSC_ST_SH_IR) begin
        next_tdo    = ir_shift[0];
        next_tdo_oe = 1'b1;                               // R3
      end else begin
        next_tdo_oe = 1'b0;                               // R1
      end
    end
    if (state == BSC_ST_RESET) begin
      next_ir = BSC_IR_RESET;                             // R11
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_shift   <= BSC_IR_CAPTURE;
      ir         <= BSC_IR_RESET;
      bypass_bit <= 1'b0;
      tdo        <= 1'b0;
      tdo_oe     <= 1'b0;
    end else begin
      ir_shift   <= next_ir_shift;
      ir         <= next_ir;
      bypass_bit <= next_bypass_bit;
      tdo        <= next_tdo;
      tdo_oe     <= next_tdo_oe;
    end
  end

  // ==========================================================
  // Boundary register control
  assign boundary_sel = (ir == BSC_OP_EXTEST) || (ir == BSC_OP_SAMPLE);
  assign extest_on    = (ir == BSC_OP_EXTEST);
  assign bs_capture   = tck_rise && (state == BSC_ST_CAP_DR) && boundary_sel;  // R11
  assign bs_shift     = tck_rise && (state == BSC_ST_SH_DR) && boundary_sel;   // R5
  assign bs_update    = tck_fall && (state == BSC_ST_UPD_DR) && boundary_sel;  // R11

  // Cells in pin order, test pins of the small variant included
  bsc_boundary_reg u_boundary (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .capture    (bs_capture),
    .shift      (bs_shift),
    .update     (bs_update),
    .tdi_bit    (tdi_sync),
    .pin_sample (pin_sync),                               // R4 R7 R8 R9 R10
    .chain      (chain),
    .latch      (latch)
  );

  // ==========================================================
  // Pin side: latches drive output cells only under EXTEST
  always_comb begin
    next_pin_drive    = core_drive;                       // R12
    next_pin_drive_oe = core_drive_oe;
    if (extest_on) begin
      next_pin_drive    = (latch & BSC_OUT_MASK) | (core_drive & ~BSC_OUT_MASK);  // R10
      next_pin_drive_oe = core_drive_oe | BSC_OUT_MASK;
    end
  end

  // Pin drive leaves flip-flops, one core cycle behind
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_drive    <= BSC_CHAIN_RESET;
      pin_drive_oe <= BSC_CHAIN_RESET;
    end else begin
      pin_drive    <= next_pin_drive;
      pin_drive_oe <= next_pin_drive_oe;
    end
  end

  // ==========================================================
  // Helper: run of TMS highs seen at test clock rises
  always_comb begin
    next_ones_cnt = ones_cnt;
    if (tck_rise) begin
      next_ones_cnt = tms_sync ? ((ones_cnt == BSC_TLR_ONES) ? ones_cnt : ones_cnt + 3'h1) : 3'h0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ones_cnt <= 3'h0;
    end else begin
      ones_cnt <= next_ones_cnt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_state_on_rise: assert property ($changed(state) |-> $past(tck_rise))  // R2
    else $error("controller moved without a test clock rise");
  a_tdo_on_fall: assert property ($changed(tdo) |-> $past(tck_fall))  // R3
    else $error("test output changed without a test clock fall");
  a_five_ones_reset: assert property (ones_cnt == BSC_TLR_ONES |-> state == BSC_ST_RESET)  // R11
    else $error("five TMS highs did not reach reset");
  a_ir_capture_val: assert property (tck_rise && state == BSC_ST_CAP_IR |=> ir_shift == BSC_IR_CAPTURE)  // R11
    else $error("instruction capture pattern wrong");
  a_cell1_first_out: assert property (tck_fall && state == BSC_ST_SH_DR && boundary_sel
                                      |=> tdo == $past(chain[0]) && tdo_oe)  // R6
    else $error("cell 1 not presented on test output");
  a_bypass_one_bit: assert property (tck_fall && state == BSC_ST_SH_DR && ir == BSC_OP_BYPASS
                                     |=> tdo == $past(bypass_bit))  // R11
    else $error("bypass path not one bit");
  a_tdo_idle_off: assert property (tdo_oe |-> state inside {BSC_ST_SH_DR, BSC_ST_SH_IR,
                                                            BSC_ST_EX1_DR, BSC_ST_EX1_IR})  // R1
    else $error("test output enabled outside a shift");
  a_pins_transparent: assert property (!extest_on |=> pin_drive == $past(core_drive)
                                       && pin_drive_oe == $past(core_drive_oe))  // R12
    else $error("pins not transparent outside EXTEST");
  a_extest_drive: assert property (extest_on |=> (pin_drive & BSC_OUT_MASK) == ($past(latch) & BSC_OUT_MASK)
                                   && (pin_drive_oe & BSC_OUT_MASK) == BSC_OUT_MASK)  // R4
    else $error("EXTEST does not drive output cells from latches");

endmodule : bsc_boundary_scan

// [shared/bsc_pkg.sv]
// ============================================================
// Boundary-scan shared constants and types
package bsc_pkg;

  // ==========================================================
  // Chain geometry
  localparam int BSC_CHAIN_LEN = 59;                      // Cells between test input and test output
  localparam int BSC_IR_LEN    = 2;                       // Instruction register width

  // Cell positions, index 0 is cell 1 next to the test output
  localparam int BSC_POS_LAYER_BYPASS  = 0;               // Layer bypass, test pin on the small variant
  localparam int BSC_POS_OVERLAY_HI    = 1;               // overlay_select bit 4
  localparam int BSC_POS_COMPOSITE_HI  = 2;               // composite_in bits 7..4
  localparam int BSC_POS_OVERLAY_LO    = 6;               // overlay_select bits 3..0
  localparam int BSC_POS_PIXEL_DATA    = 10;              // pixel_data bits 23..0
  localparam int BSC_POS_LOAD_STROBE   = 34;              // load_strobe
  localparam int BSC_POS_PIXEL_CLOCK   = 35;              // pixel_clock
  localparam int BSC_POS_GENLOCK_SYNC  = 36;              // genlock_vsync, genlock_hsync
  localparam int BSC_POS_COMPOSITE_LO  = 38;              // composite_in bits 3..0
  localparam int BSC_POS_KEY           = 42;              // key
  localparam int BSC_POS_RESET         = 43;              // reset
  localparam int BSC_POS_HOST_CTRL     = 44;              // chip_select, read_write, host_addr 1..0
  localparam int BSC_POS_PIXEL_CTRL    = 48;              // pixel_data_control
  localparam int BSC_POS_VIDEO_SYNC    = 49;              // video_hsync, video_vsync
  localparam int BSC_POS_HOST_DATA     = 51;              // host_data bits 7..0, last is next to input

  // Cells that can drive their pin: video syncs and host data
  localparam logic [58:0] BSC_OUT_MASK = 59'h7FE000000000000;

  // ==========================================================
  // Instructions
  localparam logic [1:0] BSC_OP_EXTEST  = 2'h0;           // Drive pins from update latches
  localparam logic [1:0] BSC_OP_SAMPLE  = 2'h1;           // Sample and preload, pins untouched
  localparam logic [1:0] BSC_OP_BYPASS  = 2'h3;           // One-bit bypass path
  localparam logic [1:0] BSC_IR_CAPTURE = 2'h1;           // Fixed pattern captured into the IR
  localparam logic [1:0] BSC_IR_RESET   = 2'h3;           // Instruction after reset

  // Reset values
  localparam logic [58:0] BSC_CHAIN_RESET = 59'h000000000000000;
  localparam logic [2:0]  BSC_TLR_ONES    = 3'h5;         // TMS highs that always reach reset

  // ==========================================================
  // Test access port controller states
  typedef enum logic [3:0] {
    BSC_ST_RESET, BSC_ST_IDLE,
    BSC_ST_SEL_DR, BSC_ST_CAP_DR, BSC_ST_SH_DR, BSC_ST_EX1_DR,
    BSC_ST_PA_DR, BSC_ST_EX2_DR, BSC_ST_UPD_DR,
    BSC_ST_SEL_IR, BSC_ST_CAP_IR, BSC_ST_SH_IR, BSC_ST_EX1_IR,
    BSC_ST_PA_IR, BSC_ST_EX2_IR, BSC_ST_UPD_IR
  } bsc_tap_state_type;

endpackage : bsc_pkg

// [hdl/bsc_boundary_reg.sv]
`timescale 1ns/10ps
// ============================================================
// Boundary register: shift stage plus update latch per cell
module bsc_boundary_reg import bsc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        capture,
  input  wire logic        shift,
  input  wire logic        update,
  input  wire logic        tdi_bit,
  input  wire logic [58:0] pin_sample,
  output logic      [58:0] chain,
  output logic      [58:0] latch
);

  logic [58:0] next_chain;
  logic [58:0] next_latch;

  // ==========================================================
  // Per-cell next value, cell 59 takes the serial input
  for (genvar i = 0; i < BSC_CHAIN_LEN; i++) begin : g_cell
    always_comb begin
      next_chain[i] = chain[i];
      if (capture) begin
        next_chain[i] = pin_sample[i];
      end else if (shift) begin
        next_chain[i] = (i == BSC_CHAIN_LEN - 1) ? tdi_bit : chain[(i + 1) % BSC_CHAIN_LEN];
      end
      next_latch[i] = update ? chain[i] : latch[i];
    end
  end

  // Register stage and latch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain <= BSC_CHAIN_RESET;
      latch <= BSC_CHAIN_RESET;
    end else begin
      chain <= next_chain;
      latch <= next_latch;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_capture_pins: assert property (capture |=> chain == $past(pin_sample))  // R11
    else $error("capture did not load pin values");
  a_shift_toward_out: assert property (shift && !capture |=> chain[57:0] == $past(chain[58:1]))  // R6
    else $error("chain did not shift toward the output");
  a_tdi_at_end: assert property (shift && !capture |=> chain[58] == $past(tdi_bit))  // R10
    else $error("serial input not taken at cell 59");
  a_latch_holds: assert property (!update |=> $stable(latch))  // R11
    else $error("update latch moved without update");

endmodule : bsc_boundary_reg

// [bench/bsc_tester.sv]
`timescale 1ns/10ps
// ============================================================
// Board test controller model driving the test port
module bsc_tester import bsc_pkg::*; (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic oe_seen;                                          // All tdo_oe samples in the scan_dr shift loop high since last clear
  logic oe_now;                                           // tdo_oe as seen just before the last rise

  // Idle levels, test clock stands low between frames
  initial begin
    tck     = 1'b0;
    tms     = 1'b1;
    tdi     = 1'b0;
    oe_seen = 1'b1;
    oe_now  = 1'b1;
  end

  // One 125 ns test clock period, tdo taken just before the rise
  // Edges sit 2.5 ns off core clock edges, so no change races a sample
  task automatic step(input logic m, input logic d, output logic q);
    #2.5;
    tms = m;
    tdi = d;
    #60;
    q      = tdo;
    oe_now = tdo_oe;
    tck    = 1'b1;
    #60;
    tck = 1'b0;
    tdi = ~d;                                             // Hold over, line no longer valid
    #2.5;
  endtask : step

  // Walk through tms levels, lsb first, data ignored
  task automatic walk(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b0, q);
    end
  endtask : walk

  // Five highs reach test-logic-reset, one low to idle
  task automatic tap_reset();
    walk(8'h1F, 6);
  endtask : tap_reset

  // Instruction load from idle, returns captured pattern
  task automatic load_ir(input logic [1:0] op, output logic [1:0] cap);
    walk(8'h03, 4);
    step(1'b0, op[0], cap[0]);
    step(1'b1, op[1], cap[1]);
    walk(8'h01, 2);
  endtask : load_ir

  // Data scan from idle, cell 1 leaves first
  task automatic scan_dr(input logic [58:0] din, output logic [58:0] dout);
    walk(8'h01, 3);
    oe_seen = 1'b1;
    for (int i = 0; i < BSC_CHAIN_LEN; i++) begin
      step(i == BSC_CHAIN_LEN - 1, din[i], dout[i]);
      oe_seen = oe_seen & oe_now;
    end
    walk(8'h01, 2);
  endtask : scan_dr

endmodule : bsc_tester

// [bench/tb.sv]
`timescale 1ns/10ps
// ============================================================
// Boundary-scan testbench
module tb import bsc_pkg::*; ;
  localparam logic [58:0] PIN_A   = 59'h3A5C3F00F961E2D;   // Pin levels seen by the chain
  localparam logic [58:0] PRE_B   = 59'h5C31E2D0A5F0963;   // First shift pattern
  localparam logic [58:0] CORE_D  = 59'h2468ACE13579BDF;   // Functional drive
  localparam logic [58:0] CORE_OE = 59'h0F0F0F0F0F0F0F0;   // Functional enables

  logic        core_clk;
  logic        sys_rst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [58:0] pin_value;
  logic [58:0] core_drive;
  logic [58:0] core_drive_oe;
  logic [58:0] pin_drive;
  logic [58:0] pin_drive_oe;
  logic [58:0] dout;
  logic [1:0]  cap;
  int          fail_count;
  int          num_checks;

  bsc_boundary_scan bsc_boundary_scan_i (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_value(pin_value), .core_drive(core_drive),
    .core_drive_oe(core_drive_oe), .pin_drive(pin_drive), .pin_drive_oe(pin_drive_oe));
  bsc_tester bsc_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // System clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input logic [58:0] got, input logic [58:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Reset pulse, then pins must be transparent and tdo idle
  task automatic t_reset();
    @(negedge core_clk) sys_rst = 1'b1;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(59'(tdo), 59'h0);
    check(59'(tdo_oe), 59'h0);
    check(pin_drive, core_drive);
    check(pin_drive_oe, core_drive_oe);
    bsc_tester_i.tap_reset();
  endtask : t_reset

  // Sample and preload: capture order, pins untouched
  task automatic t_sample();
    bsc_tester_i.load_ir(BSC_OP_SAMPLE, cap);
    check(59'(cap), 59'(BSC_IR_CAPTURE));
    bsc_tester_i.scan_dr(PRE_B, dout);
    check(dout, PIN_A);
    check(59'(bsc_tester_i.oe_seen), 59'h1);
    check(pin_drive, core_drive);
    check(pin_drive_oe, core_drive_oe);
  endtask : t_sample

  // Extest: shifted data reaches output cells after update
  task automatic t_extest();
    bsc_tester_i.load_ir(BSC_OP_EXTEST, cap);
    bsc_tester_i.scan_dr(~PRE_B, dout);
    check(dout, PIN_A);
    @(negedge core_clk) core_drive = ~CORE_D;
    @(negedge core_clk);
    check(pin_drive & BSC_OUT_MASK, ~PRE_B & BSC_OUT_MASK);
    check(pin_drive_oe & BSC_OUT_MASK, BSC_OUT_MASK);
    check(pin_drive & ~BSC_OUT_MASK, ~CORE_D & ~BSC_OUT_MASK);
    @(negedge core_clk) core_drive = CORE_D;
  endtask : t_extest

  // Five tms highs leave extest, pins transparent again
  task automatic t_tms_reset();
    bsc_tester_i.tap_reset();
    check(pin_drive, core_drive);
    check(pin_drive_oe, core_drive_oe);
  endtask : t_tms_reset

  // Bypass and the unused opcode give a one-bit path
  task automatic t_bypass();
    logic [1:0] ops [2];
    ops[0] = BSC_OP_BYPASS;
    ops[1] = 2'h2;
    for (int k = 0; k < 2; k++) begin
      bsc_tester_i.load_ir(ops[k], cap);
      bsc_tester_i.scan_dr(PRE_B, dout);
      check(dout, {PRE_B[57:0], 1'b0});
      check(pin_drive, core_drive);
    end
  endtask : t_bypass

  // Hang guard
  initial begin
    #200000;
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    sys_rst       = 1'b1;
    pin_value     = PIN_A;
    core_drive    = CORE_D;
    core_drive_oe = CORE_OE;
    fail_count    = 0;
    num_checks    = 0;
    t_reset();
    t_sample();
    t_extest();
    t_tms_reset();
    t_extest();
    t_reset();
    t_bypass();
    results();
  end

endmodule : tb
